// [dmac_chan_ctrl.sv]
// AXI4-Lite register slice for DMA base pointers and per-channel control
`timescale 1ns/100ps
`include "dmac_defines.svh"

// Notes on behaviour
// R1: Software aligns descriptor base to 128 bits; all 32 bits stored.
// R2: Software aligns write-back base at 0x38 to 128 bits.
// R3: Per-channel accesses go to the channel in the select index.
// R4: Software writes the channel index before channel register access.
// R5: Writing one to enable turns the channel on; zero reads disabled.
// R6: Disable during transfer keeps enable reading one until abort.
// R7: Buffer counts empty only after the current burst completes.
// R8: Channel enable stays writable while the controller is enabled.
// R9: Soft reset while disabled restores the channel's registers.
// R10: Soft reset write ignored while the channel is enabled.
// R11: Soft reset reads one while active, then clears itself.
// R12: Command field decodes none, suspend, resume, reserved.
// R13: Command field writable while controller is enabled.
// R14: Trigger action: block, reserved, beat, transaction.
// R15: Reserved bits read zero.
// R16: Software writes zeros to reserved bits.
// R17: Trigger source selects peripheral request; zero means none.
// R18: Arbitration level zero to three, higher wins.
// R19: Event action taken only with event input enabled.
// R20: Protected fields ignore writes while controller enabled.
module dmac_chan_ctrl #(
  parameter int CHANNELS = 12
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [8:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [8:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    controller_enable,
  input  wire logic [CHANNELS-1:0]     burst_busy,
  input  wire logic [CHANNELS-1:0]     event_in,
  output logic [31:0]                  descriptor_section_base,
  output logic [31:0]                  writeback_section_base,
  output dmac_pkg::chan_cfg_s [CHANNELS-1:0] chan_cfg,
  output logic [CHANNELS-1:0]          suspend_req,
  output logic [CHANNELS-1:0]          resume_req,
  output logic [CHANNELS-1:0]          event_action_fire
);

  // ==========================================================
  // Write channel
  logic        aw_held;
  logic        w_held;
  logic [8:0]  aw_addr;
  logic [6:0]  wr_idx;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic        wr_hit;
  logic        ctrl_locked;
  logic [3:0]  channel_index;
  logic        ctrl_enable_q1;
  logic        ctrl_enable_q2;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go         = aw_held && w_held;
  assign ctrl_locked   = ctrl_enable_q2;
  // Misaligned addresses fall on an unused index, so they hit nothing
  assign wr_idx        = (aw_addr[1:0] == 2'b00) ? aw_addr[8:2] : `IDX_NONE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_enable_q1 <= 1'b0;
      ctrl_enable_q2 <= 1'b0;
    end else begin
      ctrl_enable_q1 <= controller_enable;
      ctrl_enable_q2 <= ctrl_enable_q1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 9'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  function automatic logic is_mapped(input logic [6:0] idx);
    return (idx == `IDX_DESC_BASE) || (idx == `IDX_WRB_BASE) ||
           (idx == `IDX_CHAN_SELECT) || (idx == `IDX_CTRL_A) ||
           (idx == `IDX_CTRL_B) || (idx == `IDX_CTRL_STATUS);
  endfunction : is_mapped

  // Unmapped writes still get a response, so software never stalls
  assign wr_hit = is_mapped(wr_idx);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Full-word writes only; partial strobes leave registers unchanged
  logic wr_full;
  assign wr_full = wr_go && (w_strb == 4'hf);

  // ==========================================================
  // Shared registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      descriptor_section_base <= `BASE_RESET;
      writeback_section_base  <= `BASE_RESET;
    end else if (wr_full && !ctrl_locked) begin
      // R1 R2 R20: base pointers are enable protected
      if (wr_idx == `IDX_DESC_BASE) begin
        descriptor_section_base <= w_data;
      end
      if (wr_idx == `IDX_WRB_BASE) begin
        writeback_section_base <= w_data;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_index <= 4'h0;
    end else if (wr_full && (wr_idx == `IDX_CHAN_SELECT)) begin
      channel_index <= w_data[3:0];
    end
  end

  // ==========================================================
  // Channel instances
  logic [CHANNELS-1:0] ch_enable;
  logic [CHANNELS-1:0] ch_soft_reset;
  logic [31:0]         ch_ctrl_b [CHANNELS];
  logic                wr_a;
  logic                wr_b;
  logic [CHANNELS-1:0] ev_sync1;
  logic [CHANNELS-1:0] ev_sync2;

  assign wr_a = wr_full && (wr_idx == `IDX_CTRL_A);
  assign wr_b = wr_full && (wr_idx == `IDX_CTRL_B);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_sync1 <= '0;
      ev_sync2 <= '0;
    end else begin
      ev_sync1 <= event_in;
      ev_sync2 <= ev_sync1;
    end
  end

  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    dmac_chan_regs u_regs (
      .aclk          (aclk),
      .aresetn       (aresetn),
      // R3: route to the selected channel
      .sel           (channel_index == 4'(c)),
      .wr_a          (wr_a),
      .wr_b          (wr_b),
      .wdata         (w_data),
      .ctrl_locked   (ctrl_locked),
      .burst_busy    (burst_busy[c]),
      .event_in      (ev_sync2[c]),
      .enable        (ch_enable[c]),
      .soft_reset    (ch_soft_reset[c]),
      .ctrl_b        (ch_ctrl_b[c]),
      .suspend_pulse (suspend_req[c]),
      .resume_pulse  (resume_req[c]),
      .event_fire    (event_action_fire[c])
    );
    // R14 R17 R18: decoded trigger and level fields
    assign chan_cfg[c].enable                    = ch_enable[c];
    assign chan_cfg[c].peripheral_trigger_select = ch_ctrl_b[c][13:8];
    assign chan_cfg[c].trigger_action            = dmac_pkg::trigger_action_e'(ch_ctrl_b[c][23:22]);
    assign chan_cfg[c].arbitration_level         = ch_ctrl_b[c][6:5];
    assign chan_cfg[c].event_output_enable       = ch_ctrl_b[c][4];
    assign chan_cfg[c].event_input_enable        = ch_ctrl_b[c][3];
    assign chan_cfg[c].event_input_action        = dmac_pkg::event_action_e'(ch_ctrl_b[c][2:0]);
  end

  // ==========================================================
  // Read channel
  logic [31:0] rd_value;
  logic [3:0]  sel_safe;
  logic [6:0]  rd_idx;

  assign s_axi_arready = !s_axi_rvalid;
  // Misaligned reads decode to nothing and return zero
  assign rd_idx        = (s_axi_araddr[1:0] == 2'b00) ? s_axi_araddr[8:2] : `IDX_NONE;
  assign sel_safe      = (32'(channel_index) < CHANNELS) ? channel_index : 4'h0;

  always_comb begin
    rd_value = 32'h00000000;
    // R15: reserved bits read zero
    if (rd_idx == `IDX_DESC_BASE) begin
      rd_value = descriptor_section_base;
    end else if (rd_idx == `IDX_WRB_BASE) begin
      rd_value = writeback_section_base;
    end else if (rd_idx == `IDX_CHAN_SELECT) begin
      rd_value = {28'h0, channel_index};
    end else if (rd_idx == `IDX_CTRL_A) begin
      rd_value = {30'h0, ch_enable[sel_safe], ch_soft_reset[sel_safe]};
    end else if (rd_idx == `IDX_CTRL_B) begin
      rd_value = ch_ctrl_b[sel_safe] & (`CTRL_B_WMASK_OPEN | `CTRL_B_WMASK_PROT);
    end else if (rd_idx == `IDX_CTRL_STATUS) begin
      rd_value = {31'h0, ctrl_locked};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= is_mapped(rd_idx) ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  AST_BASE_LOCKED: assert property (@(posedge aclk) disable iff (!aresetn) // R20
    ctrl_locked |=> $stable(descriptor_section_base) && $stable(writeback_section_base))
    else $error("base pointer changed while controller enabled");

  AST_ENABLE_SET: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    wr_a && w_data[1] && !ch_soft_reset[channel_index] |=> ch_enable[$past(channel_index)])
    else $error("enable write did not enable channel");

  AST_DISABLE_WAITS: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    wr_a && !w_data[1] && ch_enable[channel_index] && burst_busy[channel_index]
    && !ch_soft_reset[channel_index] |=> ch_enable[$past(channel_index)])
    else $error("enable cleared during burst");

  AST_RESET_IGNORED: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    wr_a && w_data[0] && ch_enable[channel_index] && !ch_soft_reset[channel_index]
    |=> !ch_soft_reset[$past(channel_index)])
    else $error("soft reset accepted while enabled");

  AST_RESET_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    $rose(ch_soft_reset[CHANNELS-1]) |-> ##2 !ch_soft_reset[CHANNELS-1])
    else $error("soft reset did not clear itself");

  AST_SELECT_ROUTE: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    wr_b && !ctrl_locked && channel_index != 4'h0 |=> $stable(ch_ctrl_b[0]))
    else $error("write reached unselected channel");

  AST_CMD_OPEN: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    wr_b && w_data[25:24] == 2'h1 && 32'(channel_index) < CHANNELS
    && !ch_soft_reset[channel_index]
    |=> suspend_req[$past(channel_index)] && ch_ctrl_b[$past(channel_index)][25:24] == 2'h1)
    else $error("suspend command not taken");

  AST_CMD_RESUME: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    wr_b && w_data[25:24] == 2'h2 && 32'(channel_index) < CHANNELS
    |=> resume_req[$past(channel_index)])
    else $error("resume command not pulsed");

  AST_RSV_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    s_axi_rvalid && $past(rd_idx) == `IDX_CTRL_B && $past(s_axi_arready)
    && $past(s_axi_arvalid)
    |-> s_axi_rdata[31:26] == 6'h0 && s_axi_rdata[21:14] == 8'h0)
    else $error("reserved bits read non-zero");

endmodule : dmac_chan_ctrl

// [dmac_chan_regs.sv]
// One DMA channel's private control registers
`timescale 1ns/100ps
`include "dmac_defines.svh"

module dmac_chan_regs (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               sel,
  input  wire logic               wr_a,
  input  wire logic               wr_b,
  input  wire logic [31:0]        wdata,
  input  wire logic               ctrl_locked,
  input  wire logic               burst_busy,
  input  wire logic               event_in,
  output logic                    enable,
  output logic                    soft_reset,
  output logic [31:0]             ctrl_b,
  output logic                    suspend_pulse,
  output logic                    resume_pulse,
  output logic                    event_fire
);

  logic [1:0] reset_count;
  logic       disable_pending;
  logic       wa;
  logic       wb;

  assign wa = sel && wr_a;
  assign wb = sel && wr_b;

  // ==========================================================
  // Enable and soft reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable          <= 1'b0;
      disable_pending <= 1'b0;
    end else if (soft_reset) begin
      enable          <= 1'b0;
      disable_pending <= 1'b0;
    end else if (wa && wdata[`CTRL_A_ENABLE]) begin
      // R5 R8: enable write, not protected
      enable          <= 1'b1;
      disable_pending <= 1'b0;
    end else if ((wa && !wdata[`CTRL_A_ENABLE]) || disable_pending) begin
      // R6 R7: hold until the burst completes
      if (burst_busy) begin
        disable_pending <= 1'b1;
      end else begin
        enable          <= 1'b0;
        disable_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_reset  <= 1'b0;
      reset_count <= 2'h0;
    end else if (soft_reset) begin
      // R11: self clearing once done
      reset_count <= reset_count + 2'h1;
      if (reset_count == 2'(`SOFT_RESET_CYCLES - 1)) begin
        soft_reset  <= 1'b0;
        reset_count <= 2'h0;
      end
    end else if (wa && wdata[`CTRL_A_SOFT_RESET] && !enable) begin
      // R9 R10: only while disabled
      soft_reset <= 1'b1;
    end
  end

  // ==========================================================
  // Control B and commands
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      ctrl_b <= `CTRL_B_RESET;
    end else if (wb) begin
      // R13 R18 R20: command and level always, rest when unlocked
      ctrl_b <= (ctrl_b & ~(`CTRL_B_WMASK_OPEN | (ctrl_locked ? 32'h0 : `CTRL_B_WMASK_PROT)))
              | (wdata & (`CTRL_B_WMASK_OPEN | (ctrl_locked ? 32'h0 : `CTRL_B_WMASK_PROT)));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      suspend_pulse <= 1'b0;
      resume_pulse  <= 1'b0;
      event_fire    <= 1'b0;
    end else begin
      // R12: command decode
      suspend_pulse <= wb && (wdata[25:24] == 2'h1);
      resume_pulse  <= wb && (wdata[25:24] == 2'h2);
      // R19: event action gated by input enable
      event_fire    <= event_in && ctrl_b[3] && (ctrl_b[2:0] != 3'h0);
    end
  end

endmodule : dmac_chan_regs

// [dmac_defines.svh]
// Register offsets, field positions and reset values for the DMA channel control slice
`ifndef DMAC_DEFINES_SVH
`define DMAC_DEFINES_SVH

// Word indices of the registers; the byte address is four times the index
`define IDX_DESC_BASE      7'h34
`define IDX_WRB_BASE       7'h38
`define IDX_CHAN_SELECT    7'h3f
`define IDX_CTRL_A         7'h40
`define IDX_CTRL_B         7'h44
`define IDX_CTRL_STATUS    7'h50
// Index given to misaligned addresses; no register lives there
`define IDX_NONE           7'h7f

`define CTRL_A_SOFT_RESET  0
`define CTRL_A_ENABLE      1
`define CTRL_B_LEVEL_LO    5
`define CTRL_B_TRIG_LO     8
`define CTRL_B_ACT_LO      22
`define CTRL_B_CMD_LO      24
`define CTRL_B_WMASK_PROT  32'h00c03f1f
`define CTRL_B_WMASK_OPEN  32'h03000060
`define CHAN_SEL_MASK      8'h0f

`define BASE_RESET         32'h00000000
`define CTRL_B_RESET       32'h00000000

`define SOFT_RESET_CYCLES  2

`endif

// [dmac_engine_model.sv]
// Behavioural transfer engine that drives burst and event inputs of the slice
`timescale 1ns/100ps

module dmac_engine_model #(
  parameter int CHANNELS = 12
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                start,
  input  wire logic [3:0]          chan,
  input  wire logic [7:0]          len,
  input  wire logic                ev,
  output logic [CHANNELS-1:0]      burst_busy,
  output logic [CHANNELS-1:0]      event_in
);
  // ==========================================================
  // Burst timer
  logic [7:0] left;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left <= 8'h00;
    end else if (start) begin
      left <= len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end

  assign burst_busy = (left != 8'h00) ? (CHANNELS'(1) << chan) : '0;
  assign event_in   = ev ? (CHANNELS'(1) << chan) : '0;
endmodule : dmac_engine_model

// [dmac_pkg.sv]
// Types shared by the DMA channel control slice
package dmac_pkg;

  typedef enum logic [1:0] {
    CMD_NO_OPERATION,
    CMD_SUSPEND,
    CMD_RESUME,
    CMD_RESERVED
  } sw_command_e;

  typedef enum logic [1:0] {
    ACT_BLOCK,
    ACT_RESERVED,
    ACT_BEAT,
    ACT_TRANSACTION
  } trigger_action_e;

  typedef enum logic [2:0] {
    EV_NONE,
    EV_TRIGGER,
    EV_COND_TRIGGER,
    EV_COND_BLOCK,
    EV_SUSPEND,
    EV_RESUME,
    EV_SKIP,
    EV_RESERVED
  } event_action_e;

  // Per-channel settings handed to the transfer engine
  typedef struct packed {
    logic            enable;
    logic [5:0]      peripheral_trigger_select;
    trigger_action_e trigger_action;
    logic [1:0]      arbitration_level;
    logic            event_output_enable;
    logic            event_input_enable;
    event_action_e   event_input_action;
  } chan_cfg_s;

endpackage : dmac_pkg

// [tb_dmac_chan_ctrl.sv]
// Self-checking bench for the DMA channel control register slice
`timescale 1ns/100ps

module tb_dmac_chan_ctrl;
  // ==========================================================
  // Map and signals
  localparam logic [8:0] A_DESC = 9'h0d0, A_WRB = 9'h0e0, A_SEL = 9'h0fc;
  localparam logic [8:0] A_CA = 9'h100, A_CB = 9'h110, A_STAT = 9'h140, A_BAD = 9'h080;
  localparam logic [1:0] OK = 2'b00, ERR = 2'b10;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        arvalid = 1'b0, lock = 1'b0, start = 1'b0, ev = 1'b0;
  logic [8:0]  awaddr = 9'h000, araddr = 9'h000;
  logic [7:0]  len = 8'h14;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  chan = 4'hb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, desc_base, wrb_base;
  logic [11:0] busy, evin, susp, res, fire;
  dmac_pkg::chan_cfg_s [11:0] cfg;
  int          num_errors = 0, checks_done = 0, n_susp = 0, n_res = 0, n_fire = 0;

  dmac_chan_ctrl #(.CHANNELS(12)) i_dmac_chan_ctrl (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .controller_enable(lock), .burst_busy(busy), .event_in(evin),
    .descriptor_section_base(desc_base), .writeback_section_base(wrb_base),
    .chan_cfg(cfg), .suspend_req(susp), .resume_req(res), .event_action_fire(fire));

  dmac_engine_model #(.CHANNELS(12)) i_dmac_engine_model (
    .aclk(aclk), .aresetn(aresetn), .start(start), .chan(chan), .len(len),
    .ev(ev), .burst_busy(busy), .event_in(evin));

  initial begin
    forever #10 aclk = ~aclk;
  end

  // Pulse counters on the selected channel
  always @(posedge aclk) begin
    n_susp += (susp[11] === 1'b1);
    n_res += (res[11] === 1'b1);
    n_fire += (fire[11] === 1'b1);
  end

  // ==========================================================
  // Tasks
  task automatic give_verdict;
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic edge_n(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200) begin
      num_errors++;
      give_verdict();
    end
  endtask : edge_n

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      edge_n(n);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do edge_n(n); while (bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [31:0] exp, input logic [1:0] er,
                    input string nm);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do edge_n(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do edge_n(n); while (rvalid !== 1'b1);
    chk(nm, exp, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd

  // ==========================================================
  // Sequence
  initial begin
    int n;
    n = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_WRB, 32'h0, OK, "writeback base");
    rd(A_SEL, 32'h0, OK, "channel select");
    rd(A_CA, 32'h0, OK, "control a");
    rd(A_CB, 32'h0, OK, "control b");
    rd(A_DESC, 32'h0, OK, "descriptor base");
    // Bases hold all 32 bits; aligned values only
    wr(A_DESC, 32'hdeadbee0, OK);
    wr(A_WRB, 32'h12345670, OK);
    rd(A_DESC, 32'hdeadbee0, OK, "descriptor base");
    chk("descriptor port", 32'hdeadbee0, desc_base);
    rd(A_WRB, 32'h12345670, OK, "writeback base");
    chk("writeback port", 32'h12345670, wrb_base);
    wr(A_BAD, 32'h1, ERR);
    rd(A_BAD, 32'h0, ERR, "unmapped");
    // Highest channel, index written first, reserved bits written zero
    wr(A_SEL, 32'h0000000b, OK);
    rd(A_SEL, 32'h0000000b, OK, "channel select");
    wr(A_CB, 32'h00c02c7b, OK);
    rd(A_CB, 32'h00c02c7b, OK, "control b");
    chk("ch11 cfg", 32'h000059fb, 32'(cfg[11]));
    chk("ch0 cfg", 32'h0, 32'(cfg[0]));
    for (int i = 0; i < 4; i++) begin
      if (i != 1) begin
        wr(A_CB, i << 22, OK);
        chk("trigger action", i, 32'(cfg[11].trigger_action));
      end
    end
    // Events fire only with input enable set
    for (int e = 0; e < 2; e++) begin
      wr(A_CB, (e == 0) ? 32'h9 : 32'h1, OK);
      ev <= 1'b1;
      repeat (3) @(posedge aclk);
      ev <= 1'b0;
      repeat (6) @(posedge aclk);
      chk("event fires", 32'd3, n_fire);
    end
    for (int i = 0; i < 4; i++) begin
      wr(A_CB, 32'h9 | (i << 24), OK);
      repeat (2) @(posedge aclk);
    end
    chk("suspend count", 32'd1, n_susp);
    chk("resume count", 32'd1, n_res);
    wr(A_CA, 32'h2, OK);
    rd(A_CA, 32'h2, OK, "control a");
    chk("enable port", 32'h1, 32'(cfg[11].enable));
    wr(A_CA, 32'h3, OK);
    rd(A_CB, 32'h03000009, OK, "control b");
    rd(A_CA, 32'h2, OK, "control a");
    // Disable during a burst is held off until the burst ends
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    wr(A_CA, 32'h0, OK);
    rd(A_CA, 32'h2, OK, "control a busy");
    while (busy[11] === 1'b1) edge_n(n);
    repeat (2) @(posedge aclk);
    rd(A_CA, 32'h0, OK, "control a drained");
    wr(A_CA, 32'h1, OK);
    rd(A_CA, 32'h1, OK, "soft reset busy");
    rd(A_CB, 32'h0, OK, "control b");
    rd(A_CA, 32'h0, OK, "soft reset done");
    // Controller lock keeps protected fields
    lock <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(A_STAT, 32'h1, OK, "status");
    wr(A_WRB, 32'h0, OK);
    rd(A_WRB, 32'h12345670, OK, "writeback base");
    wr(A_CB, 32'h02c00060, OK);
    rd(A_CB, 32'h02000060, OK, "control b");
    chk("resume count", 32'd2, n_res);
    wr(A_CA, 32'h2, OK);
    rd(A_CA, 32'h2, OK, "control a");
    give_verdict();
  end
endmodule : tb_dmac_chan_ctrl
